// ---- shared/sto_map.svh ----
/*
  timing counts and reset values for the torque-off interlock.
  assumes a 100 mhz core clock; included by bare name.
*/
`ifndef STO_MAP_SVH
`define STO_MAP_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define STO_CLK_PERIOD_NS   10
`define STO_PULSE_MAX_US    1000
// longest test pulse in cycles, rounded down
`define STO_PULSE_MAX_CYC   ((`STO_PULSE_MAX_US * 1000) / `STO_CLK_PERIOD_NS)
// release filter: an input must stay closed this long before it counts
`define STO_STABLE_US       2
`define STO_STABLE_CYC      (((`STO_STABLE_US * 1000) + `STO_CLK_PERIOD_NS - 1) / `STO_CLK_PERIOD_NS)
// ----------------------------------------
// reset values
// ----------------------------------------
`define STO_RST_CLOSED      1'b0
`endif

// ---- shared/sto_pkg.sv ----
/*
  types for the torque-off interlock.
  assumes nothing beyond the map header.
*/
package sto_pkg;
  typedef enum logic [1:0] {
    STO_SHUT_HALF,
    STO_SHUT_BOTH,
    STO_RELEASED
  } sto_state_t;
endpackage : sto_pkg

// ---- sim/sto_interlock_sva.sv ----
/* port checker for the interlock.
   assumes binding to sto_interlock. */
module sto_interlock_sva #(
  parameter int CNT_W      = 8,
  parameter int STABLE_CYC = 200
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_CE,
  input wire logic I_TORQUE_OFF_INPUT_A,
  input wire logic I_TORQUE_OFF_INPUT_B,
  input wire logic O_BASE_ENABLE,
  input wire logic O_SHUTOFF_MONITOR_OUTPUT,
  input wire logic O_SHUTOFF_MONITOR_CONTACT_POS,
  input wire logic O_SHUTOFF_MONITOR_CONTACT_NEG
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN || !I_CE);
  // run lengths of input patterns, frozen while the enable is low like the design
  int half_cnt;
  int both_cnt;
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN || (I_CE && I_TORQUE_OFF_INPUT_A == I_TORQUE_OFF_INPUT_B)) half_cnt <= 0;
    else if (I_CE && half_cnt < 1000) half_cnt <= half_cnt + 1;
    if (!I_RSTN || (I_CE && !(I_TORQUE_OFF_INPUT_A && I_TORQUE_OFF_INPUT_B))) both_cnt <= 0;
    else if (I_CE && both_cnt < 1000) both_cnt <= both_cnt + 1;
  end
  chk_a_open_shut: assert property (!I_TORQUE_OFF_INPUT_A [*6] |-> !O_BASE_ENABLE)
    else $error("drive with a open");
  chk_b_open_shut: assert property (!I_TORQUE_OFF_INPUT_B [*6] |-> !O_BASE_ENABLE)
    else $error("drive with b open");
  chk_release_both: assert property ($rose(O_BASE_ENABLE) |->
    $past(I_TORQUE_OFF_INPUT_A, 5) && $past(I_TORQUE_OFF_INPUT_B, 5)) else $error("early release");
  chk_half_mon: assert property (half_cnt >= STABLE_CYC + 5
    |-> !O_SHUTOFF_MONITOR_OUTPUT) else $error("monitor on with one open");
  chk_release_filt: assert property ($rose(O_BASE_ENABLE) |-> both_cnt >= STABLE_CYC + 3)
    else $error("release before filter time");
  chk_both_mon: assert property ((!I_TORQUE_OFF_INPUT_A && !I_TORQUE_OFF_INPUT_B) [*6]
    |-> O_SHUTOFF_MONITOR_OUTPUT) else $error("monitor off with both open");
  chk_contact_pair: assert property (O_SHUTOFF_MONITOR_CONTACT_POS == O_SHUTOFF_MONITOR_OUTPUT
    && O_SHUTOFF_MONITOR_CONTACT_NEG == O_SHUTOFF_MONITOR_OUTPUT) else $error("contact differs");
  chk_mon_not_run: assert property (!(O_SHUTOFF_MONITOR_OUTPUT && O_BASE_ENABLE))
    else $error("monitor closed while driving");
endmodule : sto_interlock_sva
bind sto_interlock sto_interlock_sva #(.CNT_W(CNT_W), .STABLE_CYC(STABLE_CYC)) u_sva (.I_CLK(I_CLK),
  .I_RSTN(I_RSTN), .I_CE(I_CE), .I_TORQUE_OFF_INPUT_A(I_TORQUE_OFF_INPUT_A),
  .I_TORQUE_OFF_INPUT_B(I_TORQUE_OFF_INPUT_B), .O_BASE_ENABLE(O_BASE_ENABLE),
  .O_SHUTOFF_MONITOR_OUTPUT(O_SHUTOFF_MONITOR_OUTPUT),
  .O_SHUTOFF_MONITOR_CONTACT_POS(O_SHUTOFF_MONITOR_CONTACT_POS),
  .O_SHUTOFF_MONITOR_CONTACT_NEG(O_SHUTOFF_MONITOR_CONTACT_NEG));

// ---- sim/sto_interlock_tb.sv ----
/* bench: relay model feeds the interlock.
   assumes the release filter shortened to 4 cycles. */
module sto_interlock_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, run, stop, pulse, one_a, ca, cb, en, mon, pos, neg;
  logic ce = 1'h1;
  int   failures = 0;
  int   samples_checked = 0;
  sto_partner u_rly (.i_clk(clk), .i_run(run), .i_stopped(stop), .i_pulse(pulse), .i_one_a(one_a),
    .o_a(ca), .o_b(cb));
  sto_interlock #(.STABLE_CYC(4)) uut (.I_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_TORQUE_OFF_INPUT_A(ca),
    .I_TORQUE_OFF_INPUT_B(cb), .O_BASE_ENABLE(en), .O_SHUTOFF_MONITOR_OUTPUT(mon),
    .O_SHUTOFF_MONITOR_CONTACT_POS(pos), .O_SHUTOFF_MONITOR_CONTACT_NEG(neg));
  task automatic chk(input logic s, input logic e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %0t output wrong", $time);
    end
  endtask : chk
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  // bounded wait: filter latency varies by a cycle
  task automatic settle(input logic e, input logic m);
    for (int i = 0; i < 20 && !(en === e && mon === m); i++) step();
  endtask : settle
  task automatic print_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    #3000;
    failures++;
    print_verdict();
  end
  initial begin
    {rstn, run, pulse, one_a, stop} = 5'h01;
    repeat (2) step();
    rstn = 1'h1;
    run = 1'h1;
    settle(1'h1, 1'h0);
    chk(en, 1'h1);
    chk(pos, 1'h0);
    pulse = 1'h1;
    step();
    pulse = 1'h0;
    settle(1'h0, 1'h1);
    chk(en, 1'h0);
    chk(mon, 1'h1);
    settle(1'h1, 1'h0);
    chk(en, 1'h1);
    // enable low freezes the filter: open inputs must not act until it returns
    ce = 1'h0;
    run = 1'h0;
    repeat (10) step();
    chk(en, 1'h1);
    ce = 1'h1;
    settle(1'h0, 1'h1);
    chk(mon, 1'h1);
    run = 1'h1;
    settle(1'h1, 1'h0);
    chk(en, 1'h1);
    run = 1'h0;
    one_a = 1'h1;
    settle(1'h0, 1'h0);
    chk(en, 1'h0);
    chk(mon, 1'h0);
    chk(neg, 1'h0);
    one_a = 1'h0;
    settle(1'h0, 1'h1);
    chk(en, 1'h0);
    chk(mon, 1'h1);
    chk(neg, 1'h1);
    print_verdict();
  end
endmodule : sto_interlock_tb

// ---- sim/sto_partner.sv ----
/* safety relay model driving both contacts.
   assumes bench commands change just after a clock edge. */
module sto_partner #(
  parameter int PULSE_CYC = 3
) (
  input  wire logic i_clk,
  input  wire logic i_run,
  input  wire logic i_stopped,
  input  wire logic i_pulse,
  input  wire logic i_one_a,
  output logic      o_a,
  output logic      o_b
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // test pulse opens both, far below the 1 ms limit
  always @(posedge i_clk) cnt <= #1 i_pulse ? PULSE_CYC : (cnt > 0 ? cnt - 1 : 0);
  // opens once stopped with run low or during a test pulse, both together unless a fault is commanded
  assign o_b = (i_run || !i_stopped) && cnt == 0;
  assign o_a = o_b || i_one_a;
endmodule : sto_partner

// ---- verilog/sto_in_filter.sv ----
/*
  three-flop synchroniser and level filter for one shut-off contact.
  assumes an asynchronous pin and a free-running core clock.
*/
`include "sto_map.svh"
module sto_in_filter
  import sto_pkg::*;
#(
  parameter int CNT_W      = 8,
  parameter int STABLE_CYC = 200
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  input  wire logic i_raw,
  output logic      o_closed
);
  // counter must reach STABLE_CYC-1 without wrapping
  if (STABLE_CYC < 1 || STABLE_CYC >= (1 << CNT_W)) begin : g_bad_cfg
    $error("sto_in_filter: bad STABLE_CYC");
  end
  logic [2:0]       sync_ff;
  logic [2:0]       nxt_sync;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             closed_ff;
  logic             nxt_closed;
  always_comb begin
    nxt_sync   = {sync_ff[1:0], i_raw};
    nxt_cnt    = cnt_ff;
    nxt_closed = closed_ff;
    if (sync_ff[2] == sync_ff[1]) begin
      if (!sync_ff[2]) begin
        // opening is honoured at once; safe direction needs no delay
        nxt_closed = 1'b0;
        nxt_cnt    = '0;
      end else if (!closed_ff) begin
        if (cnt_ff == CNT_W'(STABLE_CYC - 1)) begin
          nxt_closed = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
    end else begin
      nxt_cnt = '0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_ff   <= 3'h0;
      cnt_ff    <= '0;
      closed_ff <= `STO_RST_CLOSED;
    end else if (i_ce) begin
      sync_ff   <= nxt_sync;
      cnt_ff    <= nxt_cnt;
      closed_ff <= nxt_closed;
    end
  end
  assign o_closed = closed_ff;
endmodule : sto_in_filter

// ---- verilog/sto_interlock.sv ----
/*
  safe torque off interlock: two redundant shut-off contacts gate the base
  circuit; a monitor contact reports full shut-off.
  assumes contact inputs are high while closed, asynchronous to I_CLK.
*/
`include "sto_map.svh"
// Notes on behaviour
// - input a open requests shutdown; only closed permits drive. code freezes while I_CE is low, so an open input leaves drive as it was.
// - input b open requests shutdown, independently of input a. code freezes while I_CE is low, so an open input leaves drive as it was.
// - release only with both inputs on; otherwise base circuit stays off.
// - monitor asserted only when both inputs off; one off deasserts it.
// - monitor contact closed only with both inputs off, open while released or with one input off.
module sto_interlock
  import sto_pkg::*;
#(
  parameter int CNT_W      = 8,
  parameter int STABLE_CYC = `STO_STABLE_CYC
) (
  input  wire logic I_CLK,
  input  wire logic I_RSTN,
  input  wire logic I_CE,
  input  wire logic I_TORQUE_OFF_INPUT_A,
  input  wire logic I_TORQUE_OFF_INPUT_B,
  output logic      O_BASE_ENABLE,
  output logic      O_SHUTOFF_MONITOR_OUTPUT,
  output logic      O_SHUTOFF_MONITOR_CONTACT_POS,
  output logic      O_SHUTOFF_MONITOR_CONTACT_NEG
);
  // ----------------------------------------
  // input filtering
  // ----------------------------------------
  logic a_closed;
  logic b_closed;
  // each channel filtered separately so a stuck channel cannot mask the other
  sto_in_filter #(.CNT_W(CNT_W), .STABLE_CYC(STABLE_CYC)) u_filt_a (
    .i_clk    (I_CLK),
    .i_rstn   (I_RSTN),
    .i_ce     (I_CE),
    .i_raw    (I_TORQUE_OFF_INPUT_A),
    .o_closed (a_closed)
  );
  sto_in_filter #(.CNT_W(CNT_W), .STABLE_CYC(STABLE_CYC)) u_filt_b (
    .i_clk    (I_CLK),
    .i_rstn   (I_RSTN),
    .i_ce     (I_CE),
    .i_raw    (I_TORQUE_OFF_INPUT_B),
    .o_closed (b_closed)
  );
  // ----------------------------------------
  // interlock state
  // ----------------------------------------
  sto_state_t state_ff;
  sto_state_t nxt_state;
  logic       en_ff;
  logic       nxt_en;
  logic       mon_ff;
  logic       nxt_mon;
  always_comb begin
    case ({a_closed, b_closed})
      2'b11:   nxt_state = STO_RELEASED;
      2'b00:   nxt_state = STO_SHUT_BOTH;
      default: nxt_state = STO_SHUT_HALF;
    endcase
    case (nxt_state)
      STO_RELEASED: begin
        nxt_en  = 1'b1;
        nxt_mon = 1'b0;
      end
      STO_SHUT_BOTH: begin
        nxt_en  = 1'b0;
        nxt_mon = 1'b1;
      end
      STO_SHUT_HALF: begin
        // half-open is a fault hint: stay off but do not report clean shut-off
        nxt_en  = 1'b0;
        nxt_mon = 1'b0;
      end
      default: begin
        nxt_en  = 1'b0;
        nxt_mon = 1'b0;
      end
    endcase
  end
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_ff <= STO_SHUT_BOTH;
      en_ff    <= 1'b0;
      mon_ff   <= 1'b1;
    end else if (I_CE) begin
      state_ff <= nxt_state;
      en_ff    <= nxt_en;
      mon_ff   <= nxt_mon;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign O_BASE_ENABLE                 = en_ff;
  assign O_SHUTOFF_MONITOR_OUTPUT      = mon_ff;
  // contact pair modelled as two closure drives of one relay
  assign O_SHUTOFF_MONITOR_CONTACT_POS = mon_ff;
  assign O_SHUTOFF_MONITOR_CONTACT_NEG = mon_ff;
endmodule : sto_interlock
